// ---- design/sbh_consts.svh ----
// Register offsets, field positions, reset values and timing counts of the serial-bus byte access host
`ifndef SBH_CONSTS_SVH
`define SBH_CONSTS_SVH

`define SBH_OFF_TRANSFER_BYTE 8'hb0
`define SBH_OFF_BYTE_ADDRESS 8'hb1
`define SBH_OFF_TARGET_ADDRESS 8'hb2
`define SBH_OFF_CTRL_STATUS 8'hb3

`define SBH_RST_BYTE 8'h00

`define SBH_BIT_SHORT_PROTOCOL 7
`define SBH_BIT_REQUEST_BUSY 5
`define SBH_BIT_FAST_CLOCK_TEST 2
`define SBH_BIT_REQUEST_ERROR 1

`define SBH_LINK_PERIOD_PS 30000
`define SBH_NORMAL_SCL_PERIOD_NS 10000
`define SBH_TEST_SCL_PERIOD_NS 1000
`define SBH_NORMAL_QUARTER_CYC \
	((`SBH_NORMAL_SCL_PERIOD_NS * 1000 + 4 * `SBH_LINK_PERIOD_PS - 1) / (4 * `SBH_LINK_PERIOD_PS))
`define SBH_TEST_QUARTER_CYC \
	((`SBH_TEST_SCL_PERIOD_NS * 1000 + 4 * `SBH_LINK_PERIOD_PS - 1) / (4 * `SBH_LINK_PERIOD_PS))
`define SBH_LAST_BIT 4'h8

`endif

// ---- design/sbh_host.sv ----
// Serial-bus byte access host: register file, crossing and two-wire bit engine
`timescale 1ns/1ps
`include "sbh_consts.svh"
module sbh_host (
	// System clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Link clock
	input wire logic clk_link_in,
	// Serial clock pin
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	// Serial data pin
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out
);
	////////////////////////////////////////////////////////////////////////////
	// System domain registers
	logic [7:0] data_q;
	logic [7:0] index_q;
	logic [7:0] target_q;
	logic short_q;
	logic test_q;
	logic err_q;
	logic busy_q;
	logic req_tgl_q;
	logic done_seen_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic done_tgl_sys;
	// Link domain results, stable while busy is clear
	logic [7:0] rx_byte_q;
	logic nack_q;
	logic done_tgl_q;

	wire wr_data = reg_wr_in && (reg_addr_in == `SBH_OFF_TRANSFER_BYTE) && !busy_q;
	wire wr_index = reg_wr_in && (reg_addr_in == `SBH_OFF_BYTE_ADDRESS) && !busy_q;
	wire wr_target = reg_wr_in && (reg_addr_in == `SBH_OFF_TARGET_ADDRESS) && !busy_q;
	wire wr_ctrl = reg_wr_in && (reg_addr_in == `SBH_OFF_CTRL_STATUS);
	wire done_evt = done_tgl_sys != done_seen_q;
	wire err_clr = wr_ctrl && reg_wdata_in[`SBH_BIT_REQUEST_ERROR];
	wire err_d = (done_evt && nack_q) || (err_q && !err_clr);
	wire [7:0] status = {short_q, 1'b0, busy_q, 2'b00, test_q, err_q, 1'b0};
	wire [7:0] rd_mux = (reg_addr_in == `SBH_OFF_TRANSFER_BYTE) ? data_q :
		(reg_addr_in == `SBH_OFF_BYTE_ADDRESS) ? index_q :
		(reg_addr_in == `SBH_OFF_TARGET_ADDRESS) ? target_q :
		(reg_addr_in == `SBH_OFF_CTRL_STATUS) ? status : `SBH_RST_BYTE;

	sbh_sync #(.AGREE(1'b0)) u_done_sync (
		.clk_in(clk_sys_in),
		.d_in(done_tgl_q),
		.q_out(done_tgl_sys)
	);

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			data_q <= `SBH_RST_BYTE;
			index_q <= `SBH_RST_BYTE;
			target_q <= `SBH_RST_BYTE;
			short_q <= 1'b0;
			test_q <= 1'b0;
			err_q <= 1'b0;
			busy_q <= 1'b0;
			req_tgl_q <= 1'b0;
			done_seen_q <= 1'b0;
			rdata_q <= `SBH_RST_BYTE;
			rvalid_q <= 1'b0;
		end else begin
			done_seen_q <= done_tgl_sys;
			err_q <= err_d;
			rvalid_q <= reg_rd_in;
			rdata_q <= reg_rd_in ? rd_mux : rdata_q;
			if (wr_data) begin
				data_q <= reg_wdata_in;
			end else if (done_evt && target_q[0] && !nack_q) begin
				data_q <= rx_byte_q;
			end
			if (wr_index) begin
				index_q <= reg_wdata_in;
			end
			if (wr_target) begin
				target_q <= reg_wdata_in;
				busy_q <= 1'b1;
				req_tgl_q <= !req_tgl_q;
			end else if (done_evt) begin
				busy_q <= 1'b0;
			end
			if (wr_ctrl) begin
				short_q <= reg_wdata_in[`SBH_BIT_SHORT_PROTOCOL];
				test_q <= reg_wdata_in[`SBH_BIT_FAST_CLOCK_TEST];
			end
		end
	end

	assign reg_rdata_out = rdata_q;
	assign reg_rvalid_out = rvalid_q;

	////////////////////////////////////////////////////////////////////////////
	// Link domain crossing
	logic link_rst_n;
	logic req_tgl_link;
	logic sda_v;
	logic scl_v;

	sbh_sync #(.AGREE(1'b0)) u_rst_sync (
		.clk_in(clk_link_in),
		.d_in(rst_n_in),
		.q_out(link_rst_n)
	);
	sbh_sync #(.AGREE(1'b0)) u_req_sync (
		.clk_in(clk_link_in),
		.d_in(req_tgl_q),
		.q_out(req_tgl_link)
	);
	sbh_sync #(.AGREE(1'b1)) u_sda_sync (
		.clk_in(clk_link_in),
		.d_in(sda_in),
		.q_out(sda_v)
	);
	sbh_sync #(.AGREE(1'b1)) u_scl_sync (
		.clk_in(clk_link_in),
		.d_in(scl_in),
		.q_out(scl_v)
	);

	////////////////////////////////////////////////////////////////////////////
	// Link domain bit engine
	sbh_pkg::sbh_state_e state_q;
	sbh_pkg::sbh_step_e step_q;
	logic req_seen_q;
	logic [7:0] div_q;
	logic [1:0] qtr_q;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	logic rx_q;
	logic fast_q;
	logic read_q;
	logic short_l_q;
	logic scl_low_q;
	logic sda_low_q;

	wire req_evt = req_tgl_link != req_seen_q;
	wire [7:0] quarter = fast_q ? 8'(`SBH_TEST_QUARTER_CYC) : 8'(`SBH_NORMAL_QUARTER_CYC);
	wire stretch = (qtr_q == 2'd2) && !scl_low_q && !scl_v;
	wire tick = (div_q == quarter - 8'd1) && !stretch;
	wire last_bit = bit_q == `SBH_LAST_BIT;
	wire tx_drive = !rx_q && !last_bit && !shift_q[7];
	wire [7:0] addr_w = {target_q[7:1], 1'b0};
	wire [7:0] addr_r = {target_q[7:1], 1'b1};

	always_ff @(posedge clk_link_in) begin
		if (!link_rst_n) begin
			state_q <= sbh_pkg::ST_IDLE;
			step_q <= sbh_pkg::STEP_ADDR;
			req_seen_q <= 1'b0;
			done_tgl_q <= 1'b0;
			div_q <= 8'h00;
			qtr_q <= 2'd0;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			rx_q <= 1'b0;
			fast_q <= 1'b0;
			read_q <= 1'b0;
			short_l_q <= 1'b0;
			nack_q <= 1'b0;
			rx_byte_q <= 8'h00;
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
		end else begin
			div_q <= (tick || state_q == sbh_pkg::ST_IDLE) ? 8'h00 : (stretch ? div_q : div_q + 8'd1);
			if (tick) begin
				qtr_q <= qtr_q + 2'd1;
			end
			case (state_q)
				sbh_pkg::ST_IDLE: begin
					qtr_q <= 2'd0;
					if (req_evt) begin
						req_seen_q <= req_tgl_link;
						fast_q <= test_q;
						read_q <= target_q[0];
						short_l_q <= short_q;
						nack_q <= 1'b0;
						step_q <= sbh_pkg::STEP_ADDR;
						shift_q <= (target_q[0] && short_q) ? addr_r : addr_w;
						state_q <= sbh_pkg::ST_START;
					end
				end
				sbh_pkg::ST_START: begin
					if (tick) begin
						case (qtr_q)
							2'd0: sda_low_q <= 1'b0;
							2'd1: scl_low_q <= 1'b0;
							2'd2: sda_low_q <= 1'b1;
							default: begin
								scl_low_q <= 1'b1;
								bit_q <= 4'h0;
								rx_q <= 1'b0;
								state_q <= sbh_pkg::ST_BYTE;
							end
						endcase
					end
				end
				sbh_pkg::ST_BYTE: begin
					if (tick) begin
						case (qtr_q)
							2'd0: sda_low_q <= tx_drive;
							2'd1: scl_low_q <= 1'b0;
							2'd2: begin
								if (rx_q && !last_bit) begin
									shift_q <= {shift_q[6:0], sda_v};
								end
								if (!rx_q && last_bit) begin
									nack_q <= sda_v;
								end
							end
							default: begin
								scl_low_q <= 1'b1;
								bit_q <= bit_q + 4'h1;
								if (!rx_q && !last_bit) begin
									shift_q <= {shift_q[6:0], 1'b0};
								end
								if (last_bit) begin
									bit_q <= 4'h0;
									sda_low_q <= 1'b0;
									if (rx_q) begin
										rx_byte_q <= shift_q;
										state_q <= sbh_pkg::ST_STOP;
									end else if (nack_q) begin
										state_q <= sbh_pkg::ST_STOP;
									end else begin
										case (step_q)
											sbh_pkg::STEP_ADDR: begin
												if (short_l_q && read_q) begin
													rx_q <= 1'b1;
												end else if (short_l_q) begin
													shift_q <= data_q;
													step_q <= sbh_pkg::STEP_DATA;
												end else begin
													shift_q <= index_q;
													step_q <= sbh_pkg::STEP_INDEX;
												end
											end
											sbh_pkg::STEP_INDEX: begin
												if (read_q) begin
													shift_q <= addr_r;
													step_q <= sbh_pkg::STEP_READ_ADDR;
													state_q <= sbh_pkg::ST_START;
												end else begin
													shift_q <= data_q;
													step_q <= sbh_pkg::STEP_DATA;
												end
											end
											sbh_pkg::STEP_READ_ADDR: rx_q <= 1'b1;
											default: state_q <= sbh_pkg::ST_STOP;
										endcase
									end
								end
							end
						endcase
					end
				end
				sbh_pkg::ST_STOP: begin
					if (tick) begin
						case (qtr_q)
							2'd0: sda_low_q <= 1'b1;
							2'd1: scl_low_q <= 1'b0;
							2'd2: sda_low_q <= 1'b0;
							default: begin
								done_tgl_q <= !done_tgl_q;
								state_q <= sbh_pkg::ST_IDLE;
							end
						endcase
					end
				end
				default: state_q <= sbh_pkg::ST_IDLE;
			endcase
		end
	end

	// Open-drain pins: drive low only
	assign scl_out = 1'b0;
	assign scl_oe_out = scl_low_q;
	assign sda_out = 1'b0;
	assign sda_oe_out = sda_low_q;
endmodule : sbh_host

// ---- design/sbh_pkg.sv ----
// Types of the serial-bus byte access host
package sbh_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_BYTE,
		ST_STOP
	} sbh_state_e;

	typedef enum logic [1:0] {
		STEP_ADDR,
		STEP_INDEX,
		STEP_DATA,
		STEP_READ_ADDR
	} sbh_step_e;
endpackage : sbh_pkg

// ---- design/sbh_sync.sv ----
// Level synchroniser: two flops, or four with agreement filter for pins
`timescale 1ns/1ps
module sbh_sync #(
	parameter bit AGREE = 1'b0
) (
	// Clock
	input wire logic clk_in,
	// Level
	input wire logic d_in,
	output logic q_out
);
	logic s1_q;
	logic s2_q;

	always_ff @(posedge clk_in) begin
		s1_q <= d_in;
		s2_q <= s1_q;
	end

	generate
		if (AGREE) begin : g_agree
			logic s3_q;
			logic held_q;
			always_ff @(posedge clk_in) begin
				s3_q <= s2_q;
				if (s2_q == s3_q) begin
					held_q <= s3_q;
				end
			end
			assign q_out = held_q;
		end else begin : g_plain
			assign q_out = s2_q;
		end
	endgenerate
endmodule : sbh_sync

// ---- testbench/sbh_host_assertions.sv ----
// Port checker of the serial-bus byte access host
`timescale 1ns/1ps
module sbh_host_assertions (
	// Clocks and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic clk_link_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	// Pins
	input wire logic scl_out,
	input wire logic scl_oe_out,
	input wire logic sda_out,
	input wire logic sda_oe_out
);
	property p_rd_answer;
		@(posedge clk_sys_in) disable iff (!rst_n_in) reg_rd_in |=> reg_rvalid_out;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_no_spurious;
		@(posedge clk_sys_in) disable iff (!rst_n_in) reg_rvalid_out |-> $past(reg_rd_in);
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("answer without read");
	property p_unmapped;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		reg_rd_in && (reg_addr_in < 8'hb0 || reg_addr_in > 8'hb3) |=> reg_rdata_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_spare_bits;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		reg_rd_in && reg_addr_in == 8'hb3 |=> (reg_rdata_out & 8'h59) == 8'h00;
	endproperty
	a_spare_bits: assert property (p_spare_bits) else $error("status spare bits set");
	property p_busy_set;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		reg_wr_in && reg_addr_in == 8'hb2 ##[1:2] reg_rd_in && reg_addr_in == 8'hb3 |=> reg_rdata_out[5];
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set by start");
	property p_open_drain;
		@(posedge clk_link_in) disable iff (!rst_n_in) !scl_out && !sda_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin driven high");
	property p_idle_release;
		@(posedge clk_link_in) disable iff (!rst_n_in) $rose(rst_n_in) |-> !scl_oe_out && !sda_oe_out;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("bus held after reset");
	property p_scl_low;
		@(posedge clk_link_in) disable iff (!rst_n_in) $rose(scl_oe_out) |=> scl_oe_out [*8];
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("clock low phase short");
endmodule : sbh_host_assertions
bind sbh_host sbh_host_assertions u_chk (.clk_sys_in, .rst_n_in, .clk_link_in, .reg_addr_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .scl_out, .scl_oe_out, .sda_out, .sda_oe_out);

// ---- testbench/sbh_target_model.sv ----
// Two-wire target with a byte memory
`timescale 1ns/1ps
module sbh_target_model #(
	parameter logic [6:0] ADDR = 7'h50
) (
	// Pins and fault control
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic nack_in,
	output logic sda_oe_out
);
	logic [7:0] mem [256];
	logic [7:0] sh, tx, ptr;
	logic oe;
	int b, st;
	initial begin
		sda_oe_out = 0;
		st = 0;
		ptr = 0;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
	end
	always @(negedge sda_in) if (scl_in) begin
		st = 1;
		b = 0;
	end
	always @(posedge sda_in) if (scl_in) st = 0;
	always @(posedge scl_in) if (st != 0) begin
		if (b < 8) sh = {sh[6:0], sda_in};
		if (b == 8 && st == 4 && sda_in) st = 0;
		b++;
	end
	always @(negedge scl_in) if (st != 0) begin
		oe = 0;
		if (b == 8 && st != 4) begin
			if (st == 1) st = (sh[7:1] == ADDR && !nack_in) ? (sh[0] ? 4 : 2) : 0;
			else if (st == 2) begin
				ptr = sh;
				st = 3;
			end else begin
				mem[ptr] = sh;
				ptr++;
			end
			tx = mem[ptr];
			oe = st != 0;
		end else if (b == 9) b = 0;
		if (st == 4 && b < 8) oe = !tx[7 - b];
		sda_oe_out = oe;
	end
endmodule : sbh_target_model

// ---- testbench/serial_bus_byte_access_host_tb.sv ----
// Testbench of the serial-bus byte access host
`timescale 1ns/1ps
module serial_bus_byte_access_host_tb;
	logic clk_sys_in = 0, clk_link_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, nack = 0;
	logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, v, d, x;
	logic reg_rvalid_out, scl_out, scl_oe_out, sda_out, sda_oe_out, tgt_oe;
	logic [31:0] seed = 32'h0000_55fe;
	int n_errors = 0, checks = 0, exp_mem [256];
	realtime t0, per;
	wire logic scl = !scl_oe_out;
	wire logic sda = !(sda_oe_out | tgt_oe);
	always #4 clk_sys_in = !clk_sys_in;
	initial #7 forever #15 clk_link_in = !clk_link_in;
	always @(posedge scl) begin
		per = $realtime - t0;
		t0 = $realtime;
	end
	sbh_host dut (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
		.reg_rvalid_out, .clk_link_in, .scl_in(scl), .scl_out, .scl_oe_out, .sda_in(sda), .sda_out, .sda_oe_out);
	sbh_target_model #(.ADDR(7'h50)) u_tgt (.scl_in(scl), .sda_in(sda), .nack_in(nack), .sda_oe_out(tgt_oe));
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge clk_sys_in);
		#1 reg_addr_in = a;
		reg_wdata_in = w;
		reg_wr_in = 1;
		@(posedge clk_sys_in);
		#1 reg_wr_in = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		@(posedge clk_sys_in);
		#1 reg_addr_in = a;
		reg_rd_in = 1;
		@(posedge clk_sys_in);
		#1 reg_rd_in = 0;
		chk("rvalid", {7'h0, reg_rvalid_out}, 8'h01);
		r = reg_rdata_out;
	endtask : rd
	task automatic xfer(input logic [7:0] a, input logic [7:0] st_exp);
		int i;
		wr(8'hb2, a);
		rd(8'hb3, v);
		chk("busy", v & 8'h20, 8'h20);
		for (i = 0; i < 30000 && v[5] !== 1'h0; i++) rd(8'hb3, v);
		chk("status", v & 8'h22, st_exp);
	endtask : xfer
	task automatic test_done();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_sys_in);
		#1 rst_n_in = 1;
		for (int i = 0; i < 256; i++) exp_mem[i] = i ^ 8'h5a;
		for (int a = 8'hb0; a < 8'hb4; a++) begin
			rd(8'(a), v);
			chk("reset", v, 8'h00);
		end
		x = rnd();
		if (x[7:2] == 6'h2c) x ^= 8'h40;
		rd(x, v);
		chk("unmapped", v, 8'h00);
		$display("test reset done");
		wr(8'hb3, 8'h04);
		repeat (3) begin
			d = rnd();
			x = rnd();
			wr(8'hb0, d);
			wr(8'hb1, x);
			rd(8'hb1, v);
			chk("index", v, x);
			xfer({7'h50, 1'h0}, 8'h00);
			exp_mem[x] = d;
			wr(8'hb0, ~d);
			xfer({7'h50, 1'h1}, 8'h00);
			rd(8'hb0, v);
			chk("read", v, 8'(exp_mem[x]));
		end
		$display("test indexed done");
		nack = 1;
		xfer({7'h50, 1'h0}, 8'h02);
		nack = 0;
		wr(8'hb0, ~d);
		xfer({7'h51, 1'h1}, 8'h02);
		rd(8'hb0, v);
		chk("kept", v, ~d);
		wr(8'hb3, 8'h06);
		rd(8'hb3, v);
		chk("cleared", v, 8'h04);
		$display("test error done");
		wr(8'hb3, 8'h80);
		d = rnd();
		wr(8'hb0, d);
		xfer({7'h50, 1'h0}, 8'h00);
		chk("slow", {7'h0, per > 9000 && per < 11000}, 8'h01);
		wr(8'hb3, 8'h84);
		xfer({7'h50, 1'h1}, 8'h00);
		rd(8'hb0, v);
		chk("short", v, 8'(exp_mem[d]));
		chk("fast", {7'h0, per > 900 && per < 1500}, 8'h01);
		$display("test short done");
		test_done();
	end
	initial begin
		#750_000;
		n_errors++;
		test_done();
	end
endmodule : serial_bus_byte_access_host_tb
